// ---- logic/pdepc_pkg.sv ----
// shared constants and types for the two-port pin control block
package pdepc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int FP_W = 8;
  localparam int SP_W = 3;
  localparam int SLR_W = 5;
  localparam int ADR_W = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] ADR_FP_DIR = 8'h00;
  localparam logic [ADR_W-1:0] ADR_FP_LAT = 8'h04;
  localparam logic [ADR_W-1:0] ADR_FP_ANS = 8'h08;
  localparam logic [ADR_W-1:0] ADR_FP_IN = 8'h0C;
  localparam logic [ADR_W-1:0] ADR_SP_DIR = 8'h10;
  localparam logic [ADR_W-1:0] ADR_SP_LAT = 8'h14;
  localparam logic [ADR_W-1:0] ADR_SP_ANS = 8'h18;
  localparam logic [ADR_W-1:0] ADR_SP_IN = 8'h1C;
  localparam logic [ADR_W-1:0] ADR_SLEW = 8'h20;
  localparam logic [ADR_W-1:0] ADR_CFG = 8'h24;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [FP_W-1:0] FP_DIR_RST = 8'hFF;
  localparam logic [FP_W-1:0] FP_LAT_RST = 8'h00;
  localparam logic [FP_W-1:0] FP_ANS_RST = 8'hFF;
  localparam logic [SP_W-1:0] SP_DIR_RST = 3'h7;
  localparam logic [SP_W-1:0] SP_LAT_RST = 3'h0;
  localparam logic [SP_W-1:0] SP_ANS_RST = 3'h7;
  localparam logic [SLR_W-1:0] SLEW_RST = 5'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SP_IN_ONLY_BIT = 3;
  localparam int CFG_MCLR_BIT = 0;
  localparam int CFG_PROG_BIT = 1;
  localparam int PWM_FIRST_PIN = 5;
  localparam int PWM_N = 3;

  // ----------------------------------------------------------------
  // pin drive bundles
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [FP_W-1:0] level;
    logic [FP_W-1:0] enable;
  } pdepc_fp_drive_type;

  typedef struct packed {
    logic [SP_W-1:0] level;
    logic [SP_W-1:0] enable;
  } pdepc_sp_drive_type;

endpackage

// ---- logic/pdepc_top.sv ----
// pin control for the 8-bit first port and 3-pin second port
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

module pdepc_top
  import pdepc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // first port pins
  input wire logic [FP_W-1:0] first_port_pin_i,
  output pdepc_fp_drive_type first_port_drive_o,
  output logic [FP_W-1:0] first_port_analog_o,
  // pwm peripheral outputs two, three, four
  input wire logic [PWM_N-1:0] pwm_level_i,
  input wire logic [PWM_N-1:0] pwm_enable_i,
  // second port pins
  input wire logic [SP_W-1:0] second_port_pin_i,
  output pdepc_sp_drive_type second_port_drive_o,
  output logic [SP_W-1:0] second_port_analog_o,
  // input-only pin and configuration
  input wire logic input_only_pin_i,
  input wire logic master_clear_enable_i,
  input wire logic programming_mode_i,
  output logic master_clear_n_o,
  output logic programming_voltage_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [FP_W-1:0] fp_dir_q;
  logic [FP_W-1:0] fp_lat_q;
  logic [FP_W-1:0] fp_ans_q;
  logic [SP_W-1:0] sp_dir_q;
  logic [SP_W-1:0] sp_lat_q;
  logic [SP_W-1:0] sp_ans_q;
  logic [SLR_W-1:0] slew_q;
  logic ack_q;
  logic [31:0] rdat_q;
  pdepc_fp_drive_type fp_drv_q;
  pdepc_fp_drive_type fp_drv_d;
  pdepc_sp_drive_type sp_drv_q;
  logic mclr_n_q;
  logic vpp_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req = wb_cyc_i & wb_stb_i;
  wire rd_take = req & ~ack_q;
  wire wr_en = req & ack_q & wb_we_i & wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];
  wire wr_fp_dir = wr_en & (wb_adr_i == ADR_FP_DIR);
  wire wr_fp_lat = wr_en & ((wb_adr_i == ADR_FP_LAT) | (wb_adr_i == ADR_FP_IN));
  wire wr_fp_ans = wr_en & (wb_adr_i == ADR_FP_ANS);
  wire wr_sp_dir = wr_en & (wb_adr_i == ADR_SP_DIR);
  wire wr_sp_lat = wr_en & ((wb_adr_i == ADR_SP_LAT) | (wb_adr_i == ADR_SP_IN));
  wire wr_sp_ans = wr_en & (wb_adr_i == ADR_SP_ANS);
  wire wr_slew = wr_en & (wb_adr_i == ADR_SLEW);

  // ----------------------------------------------------------------
  // input paths
  // ----------------------------------------------------------------
  // analog gates input
  wire [FP_W-1:0] fp_in = first_port_pin_i & ~fp_ans_q;
  wire [SP_W-1:0] sp_in = second_port_pin_i & ~sp_ans_q;
  wire in_only = input_only_pin_i & ~master_clear_enable_i;
  wire [SP_IN_ONLY_BIT:0] sp_in_all = {in_only, sp_in};

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    case (wb_adr_i)
      ADR_FP_DIR: rmux[FP_W-1:0] = fp_dir_q;
      ADR_FP_LAT: rmux[FP_W-1:0] = fp_lat_q;
      ADR_FP_ANS: rmux[FP_W-1:0] = fp_ans_q;
      ADR_FP_IN: rmux[FP_W-1:0] = fp_in;
      ADR_SP_DIR: rmux[SP_W-1:0] = sp_dir_q;
      ADR_SP_LAT: rmux[SP_W-1:0] = sp_lat_q;
      ADR_SP_ANS: rmux[SP_W-1:0] = sp_ans_q;
      ADR_SP_IN: rmux[SP_IN_ONLY_BIT:0] = sp_in_all;
      ADR_SLEW: rmux[SLR_W-1:0] = slew_q;
      ADR_CFG: begin
        rmux[CFG_MCLR_BIT] = master_clear_enable_i;
        rmux[CFG_PROG_BIT] = programming_mode_i;
      end
      default: rmux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= rd_take;
      if (rd_take) begin
        rdat_q <= rmux;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fp_dir_q <= FP_DIR_RST;
      fp_lat_q <= FP_LAT_RST;
      fp_ans_q <= FP_ANS_RST;
      sp_dir_q <= SP_DIR_RST;
      sp_lat_q <= SP_LAT_RST;
      sp_ans_q <= SP_ANS_RST;
      slew_q <= SLEW_RST;
    end else begin
      if (wr_fp_dir) begin
        fp_dir_q <= wd;
      end
      if (wr_fp_lat) begin
        fp_lat_q <= wd;
      end
      if (wr_fp_ans) begin
        fp_ans_q <= wd;
      end
      if (wr_sp_dir) begin
        sp_dir_q <= wd[SP_W-1:0];
      end
      if (wr_sp_lat) begin
        sp_lat_q <= wd[SP_W-1:0];
      end
      if (wr_sp_ans) begin
        sp_ans_q <= wd[SP_W-1:0];
      end
      if (wr_slew) begin
        slew_q <= wd[SLR_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // first port output selection
  // ----------------------------------------------------------------
  logic [FP_W-1:0] pwm_take;
  genvar gi;
  generate
    for (gi = 0; gi < FP_W; gi++) begin : g_fp
      if (gi >= PWM_FIRST_PIN) begin : g_pwm
        assign pwm_take[gi] = pwm_enable_i[gi-PWM_FIRST_PIN] & ~fp_dir_q[gi] & ~fp_ans_q[gi];
        assign fp_drv_d.level[gi] = pwm_take[gi] ? pwm_level_i[gi-PWM_FIRST_PIN] : fp_lat_q[gi];
      end else begin : g_lat
        assign pwm_take[gi] = 1'b0;
        assign fp_drv_d.level[gi] = fp_lat_q[gi];
      end
      assign fp_drv_d.enable[gi] = ~fp_dir_q[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin drive flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fp_drv_q <= '0;
      sp_drv_q <= '0;
      mclr_n_q <= 1'b1;
      vpp_q <= 1'b0;
    end else begin
      fp_drv_q <= fp_drv_d;
      sp_drv_q.enable <= ~sp_dir_q;
      sp_drv_q.level <= sp_lat_q;
      mclr_n_q <= master_clear_enable_i ? input_only_pin_i : 1'b1;
      vpp_q <= programming_mode_i & input_only_pin_i;
    end
  end

  assign first_port_drive_o = fp_drv_q;
  assign second_port_drive_o = sp_drv_q;
  assign first_port_analog_o = fp_ans_q;
  assign second_port_analog_o = sp_ans_q;
  assign master_clear_n_o = mclr_n_q;
  assign programming_voltage_o = vpp_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  bus_ack_a: assert property (rd_take |=> wb_ack_o ##1 !wb_ack_o) // ack timing
    else $error("ack not one cycle after request");

  high_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  fp_enable_a: assert property (1'b1 |=> first_port_drive_o.enable == ~$past(fp_dir_q))
    else $error("first port enable not from direction");

  fp_latch_a: assert property (1'b1 |=> (first_port_drive_o.level & ~$past(pwm_take))
    == ($past(fp_lat_q) & ~$past(pwm_take)))
    else $error("first port level not from latch");

  pwm_prio_a: assert property (pwm_take[PWM_FIRST_PIN]
    |=> first_port_drive_o.level[PWM_FIRST_PIN] == $past(pwm_level_i[0]))
    else $error("pwm does not own pin");

  pwm_gate_a: assert property ((fp_ans_q[FP_W-1] | fp_dir_q[FP_W-1])
    |=> first_port_drive_o.level[FP_W-1] == $past(fp_lat_q[FP_W-1]))
    else $error("pwm taken on analog or input pin");

  sp_enable_a: assert property (1'b1 |=> second_port_drive_o.enable == ~$past(sp_dir_q))
    else $error("second port enable not from direction");

  sp_zero_a: assert property (rd_take && wb_adr_i == ADR_SP_IN
    |=> (wb_dat_o[SP_W-1:0] & $past(sp_ans_q)) == 3'h0)
    else $error("analog second port pin read nonzero");

  fp_gate_a: assert property (rd_take && wb_adr_i == ADR_FP_IN
    |=> (wb_dat_o[FP_W-1:0] & $past(fp_ans_q)) == 8'h00)
    else $error("analog first port pin read nonzero");

  reset_ana_a: assert property ($past(rst_i) |-> fp_ans_q == FP_ANS_RST && sp_ans_q == SP_ANS_RST)
    else $error("pins not analog after reset");

  mclr_pin_a: assert property (master_clear_enable_i
    |=> master_clear_n_o == $past(input_only_pin_i))
    else $error("master clear not following pin");

  in_only_a: assert property (rd_take && wb_adr_i == ADR_SP_IN && master_clear_enable_i
    |=> !wb_dat_o[SP_IN_ONLY_BIT])
    else $error("input-only bit visible with master clear on");

  // ----------------------------------------------------------------
  // register and reset assertions
  // ----------------------------------------------------------------
  fp_ana_wr_a: assert property (wr_fp_ans
    |=> first_port_analog_o == $past(wb_dat_i[FP_W-1:0]))
    else $error("first port analog enables not from write");

  sp_ana_wr_a: assert property (wr_sp_ans
    |=> second_port_analog_o == $past(wb_dat_i[SP_W-1:0]))
    else $error("second port analog enables not from write");

  sp_dir_wr_a: assert property (wr_sp_dir
    |=> sp_dir_q == $past(wb_dat_i[SP_W-1:0]))
    else $error("second port direction not from write");

  fp_latch_rd_a: assert property (rd_take && wb_adr_i == ADR_FP_LAT
    |=> wb_dat_o == {24'h000000, $past(fp_lat_q)})
    else $error("first port latch readback wrong");

  sp_latch_rd_a: assert property (rd_take && wb_adr_i == ADR_SP_LAT
    |=> wb_dat_o == {29'h0, $past(sp_lat_q)})
    else $error("second port latch readback wrong");

  in_write_a: assert property (wr_en && wb_adr_i == ADR_FP_IN
    |=> fp_lat_q == $past(wb_dat_i[FP_W-1:0]))
    else $error("input address write missed the latch");

  sel_mask_a: assert property (req && ack_q && wb_we_i && !wb_sel_i[0]
    |=> $stable(fp_lat_q) && $stable(sp_lat_q))
    else $error("write without lane zero changed a latch");

  unmapped_a: assert property (rd_take && wb_adr_i > ADR_CFG
    |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped address read nonzero");

  sp_high_a: assert property (rd_take && wb_adr_i == ADR_SP_DIR
    |=> wb_dat_o[31:SP_W] == 29'h0)
    else $error("unimplemented direction bits read nonzero");

  sp_reset_a: assert property ($past(rst_i)
    |-> sp_dir_q == SP_DIR_RST && second_port_analog_o == SP_ANS_RST)
    else $error("second port not analog input after reset");

  drv_reset_a: assert property ($past(rst_i)
    |-> first_port_drive_o.enable == 8'h00 && second_port_drive_o.enable == 3'h0)
    else $error("pin driver enabled right after reset");

  // ----------------------------------------------------------------
  // pin assertions
  // ----------------------------------------------------------------
  analog_drv_a: assert property (fp_ans_q[0] && !fp_dir_q[0]
    |=> first_port_drive_o.enable[0] && first_port_drive_o.level[0] == $past(fp_lat_q[0]))
    else $error("latch not driving analog-selected output pin");

  sp_level_a: assert property (1'b1
    |=> second_port_drive_o.level == $past(sp_lat_q))
    else $error("second port level not from latch");

  sp_analog_a: assert property (sp_ans_q != 3'h0
    |=> second_port_drive_o.enable == ~$past(sp_dir_q))
    else $error("direction ignored on analog second port pin");

  vpp_sense_a: assert property (1'b1
    |=> programming_voltage_o == ($past(programming_mode_i) & $past(input_only_pin_i)))
    else $error("programming voltage sense wrong");

  pin_bit_a: assert property (rd_take && wb_adr_i == ADR_SP_IN && !master_clear_enable_i
    |=> wb_dat_o[SP_IN_ONLY_BIT] == $past(input_only_pin_i))
    else $error("input-only bit hidden with master clear off");

  mclr_idle_a: assert property (!master_clear_enable_i
    |=> master_clear_n_o)
    else $error("master clear asserted while disabled");

  fp_map_a: assert property (rd_take && wb_adr_i == ADR_FP_IN
    |=> wb_dat_o[FP_W-1:0] == ($past(first_port_pin_i) & ~$past(fp_ans_q)))
    else $error("first port input bits not mapped per pin");

endmodule

`default_nettype wire

// ---- sim/pdepc_board.sv ----
// board model: resolves each pin from the block's drive and the outside circuit
`timescale 1ns/100ps
`default_nettype none
module pdepc_board
  import pdepc_pkg::*;
(
  // drives from the block
  input wire pdepc_fp_drive_type fp_drive_i,
  input wire pdepc_sp_drive_type sp_drive_i,
  // levels the outside circuit puts on undriven pins
  input wire logic [FP_W-1:0] fp_ext_i,
  input wire logic [SP_W-1:0] sp_ext_i,
  // resolved pin levels
  output logic [FP_W-1:0] fp_pin_o,
  output logic [SP_W-1:0] sp_pin_o
);
  assign fp_pin_o = (fp_drive_i.enable & fp_drive_i.level) | (~fp_drive_i.enable & fp_ext_i);
  assign sp_pin_o = (sp_drive_i.enable & sp_drive_i.level) | (~sp_drive_i.enable & sp_ext_i);
endmodule
`default_nettype wire

// ---- sim/pdepc_top_bench.sv ----
// self-checking bench for the two-port pin control block
`timescale 1ns/100ps
`default_nettype none
module pdepc_top_bench import pdepc_pkg::*; ();
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, iop = 1, mce = 0, prog = 0, ack;
  logic [ADR_W-1:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, dat_o;
  logic [7:0] fext = 0, lat, a, pwm, m;
  logic [2:0] sext = 0, pen = 0, plv = 0, spin, sana;
  logic [7:0] fpin, fana;
  logic mcn, pv;
  pdepc_fp_drive_type fdrv;
  pdepc_sp_drive_type sdrv;
  int err_count = 0, total_checks = 0;
  logic [31:0] exp_q[$];
  logic [ADR_W-1:0] adr_q[$];
  logic [7:0] ra[8] = '{ADR_FP_DIR, ADR_FP_LAT, ADR_FP_ANS, ADR_SP_DIR, ADR_SP_LAT, ADR_SP_ANS,
                        ADR_SLEW, 8'h30};
  logic [7:0] rv[8] = '{8'hFF, 8'h00, 8'hFF, 8'h07, 8'h00, 8'h07, 8'h00, 8'h00};

  pdepc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .first_port_pin_i(fpin), .first_port_drive_o(fdrv), .first_port_analog_o(fana),
    .pwm_level_i(plv), .pwm_enable_i(pen), .second_port_pin_i(spin),
    .second_port_drive_o(sdrv), .second_port_analog_o(sana), .input_only_pin_i(iop),
    .master_clear_enable_i(mce), .programming_mode_i(prog), .master_clear_n_o(mcn),
    .programming_voltage_o(pv));
  pdepc_board board (.fp_drive_i(fdrv), .sp_drive_i(sdrv), .fp_ext_i(fext), .sp_ext_i(sext),
    .fp_pin_o(fpin), .sp_pin_o(spin));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0 && exp_q.size() == 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  // one classic cycle; reads leave their expected data for the monitor
  task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d,
                     input logic [7:0] e, input logic [3:0] s);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= ad;
    sel <= s;
    dat <= {24'h0, d};
    if (!w) begin
      exp_q.push_back({24'h0, e});
      adr_q.push_back(ad);
    end
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk_i);
  endtask

  // drive outputs settle one edge after the write edge; undriven levels are not compared
  task automatic drv(input logic [15:0] f, input logic [5:0] s);
    repeat (2) @(posedge clk_i);
    #1;
    chk("first drive", f, {fdrv.level & fdrv.enable, fdrv.enable});
    chk("second drive", s, {sdrv.level & sdrv.enable, sdrv.enable});
    @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("ERROR read ack expected none seen one");
      end else begin
        chk($sformatf("read %h", adr_q.pop_front()), exp_q.pop_front(), dat_o);
      end
    end
  end

  initial begin
    #100000;
    err_count++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h6e23));
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk("first analog", 8'hFF, fana);
    chk("second analog", 8'h07, sana);
    for (int i = 0; i < 8; i++) bus(0, ra[i], 0, rv[i], 1);
    bus(0, ADR_SP_IN, 0, {4'h0, iop, 3'h0}, 1);
    $display("reset test done");
    lat = 8'($urandom);
    pwm = 8'($urandom);
    pen <= 3'h7;
    plv <= pwm[2:0];
    bus(1, ADR_FP_LAT, lat, 0, 1);
    bus(1, ADR_FP_DIR, 8'h00, 0, 1);
    drv({lat, 8'hFF}, 6'h00);
    bus(0, ADR_FP_IN, 0, 8'h00, 1);
    for (int k = 0; k < 8; k++) begin
      pen <= k[2:0];
      bus(1, ADR_FP_ANS, 8'h00, 0, 1);
      m = {k[2:0], 5'h0};
      drv({(m & {pwm[2:0], 5'h0}) | (~m & lat), 8'hFF}, 6'h00);
      bus(0, ADR_FP_IN, 0, (m & {pwm[2:0], 5'h0}) | (~m & lat), 1);
    end
    $display("first port output test done");
    a = 8'($urandom);
    fext <= ~lat;
    bus(1, ADR_FP_DIR, 8'hFF, 0, 1);
    bus(1, ADR_FP_ANS, a, 0, 1);
    drv(16'h0000, 6'h00);
    bus(0, ADR_FP_LAT, 0, lat, 1);
    bus(0, ADR_FP_IN, 0, ~lat & ~a, 1);
    bus(1, ADR_FP_LAT, 8'h55, 0, 4'hE);
    bus(0, ADR_FP_LAT, 0, lat, 1);
    bus(1, ADR_FP_IN, a, 0, 1);
    bus(0, ADR_FP_LAT, 0, a, 1);
    $display("first port input test done");
    sext <= 3'($urandom);
    bus(1, ADR_SP_LAT, 8'hFF, 0, 1);
    bus(0, ADR_SP_LAT, 0, 8'h07, 1);
    bus(1, ADR_SP_ANS, 8'h04, 0, 1);
    // only the analog pin 2 stays an input
    bus(1, ADR_SP_DIR, 8'h04, 0, 1);
    drv(16'h0000, 6'h1B);
    bus(0, ADR_SP_IN, 0, {4'h0, iop, 3'h3}, 1);
    bus(1, ADR_SP_DIR, 8'hFF, 0, 1);
    bus(0, ADR_SP_DIR, 0, 8'h07, 1);
    drv(16'h0000, 6'h00);
    $display("second port test done");
    for (int k = 0; k < 8; k++) begin
      iop <= k[0];
      mce <= k[1];
      prog <= k[2];
      repeat (2) @(posedge clk_i);
      #1;
      chk("clear out", k[1] ? k[0] : 1'b1, mcn);
      chk("prog out", k[0] & k[2], pv);
      @(posedge clk_i);
      bus(0, ADR_CFG, 0, {6'h0, k[2], k[1]}, 1);
      bus(0, ADR_SP_IN, 0, {4'h0, k[0] & ~k[1], 1'b0, sext[1:0]}, 1);
    end
    $display("input only pin test done");
    end_of_test();
  end
endmodule
`default_nettype wire
